// ### src/rcw_pkg.sv
package rcw_pkg;

    // ========================================
    // timing
    localparam int unsigned WDT_OSC_HZ = 128000;
    localparam int unsigned WDT_MIN_TIMEOUT_US = 16000;
    localparam int unsigned WDT_BASE_TICKS_DEF = WDT_OSC_HZ / 1000 * WDT_MIN_TIMEOUT_US / 1000;
    localparam int WDT_CNT_W = 20;
    localparam logic [3:0] WDT_CODE_MAX = 4'h9;
    localparam logic [2:0] UNLOCK_CYCLES = 3'h4;
    localparam int DLY_W = 16;
    localparam logic [15:0] STARTUP_CYC_0 = 16'h0004;
    localparam logic [15:0] STARTUP_CYC_1 = 16'h0010;
    localparam logic [15:0] STARTUP_CYC_2 = 16'h0040;
    localparam logic [15:0] STARTUP_CYC_3 = 16'h0100;

    // ========================================
    // register map (byte addresses)
    localparam logic [7:0] ADDR_FLAGS = 8'h00;
    localparam logic [7:0] ADDR_CTRL = 8'h04;
    localparam logic [7:0] ADDR_STATE = 8'h08;

    localparam int FLG_POR = 0;
    localparam int FLG_EXT = 1;
    localparam int FLG_BOD = 2;
    localparam int FLG_WDT = 3;
    localparam int FLG_SCAN = 4;
    localparam int FLG_W = 5;
    localparam logic [4:0] FLAGS_POR_ONLY = 5'h01;

    localparam int CTL_IRQ_FLAG = 7;
    localparam int CTL_IRQ_EN = 6;
    localparam int CTL_PER_HI = 5;
    localparam int CTL_UNLOCK = 4;
    localparam int CTL_RST_EN = 3;
    localparam int CTL_PER_LO = 0;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ========================================
    // sampled pins
    localparam int PIN_POR = 0;
    localparam int PIN_EXTN = 1;
    localparam int PIN_BOD = 2;
    localparam int PIN_SCAN = 3;
    localparam int PIN_OSC = 4;
    localparam int PIN_W = 5;
    localparam logic [4:0] PIN_IDLE = 5'h02;

    typedef enum logic [1:0] {RST_ACTIVE, RST_DELAY, RST_RUN} rcw_rst_state_type;

endpackage

// ### src/rcw_reset_watchdog.sv
// Chosen here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps

// Behaviour
// - internal reset clears all control registers; core fetches reset vector on release.
// - port-init output drops asynchronously as soon as any external source goes active.
// - after all sources drop, delay counter stretches internal reset by fused period.
// - five sources combined: power-on, reset pin, watchdog, brown-out, scan register.
// - reset pin low long enough resets even without clock; short glitches may not.
// - reset pin rising starts the delay counter; release only after it expires.
// - power-on detect asserts reset immediately; its removal starts the delay counter.
// - enabled brown-out asserts reset at once; removal starts the delay counter.
// - reset held while scan reset register holds one.
// - watchdog reset pulse is one clock; delay counting starts after it falls.
// - reference enable follows brown-out enable, comparator bandgap select or converter.
// - watchdog counts ticks of the separate 128 kHz oscillator up to the timeout.
// - restart clears watchdog counter; core must restart before timeout.
// - interrupt mode expiry raises interrupt request usable as a wake-up.
// - reset mode expiry generates a system reset.
// - combined mode: first expiry interrupts, then reset mode; later expiry resets.
// - always-on fuse forces reset mode: reset enable reads 1, irq enable 0.
// - within four cycles one write without unlock updates reset enable and period.
// - timeout selectable from 16 ms to 8 s by period select.
// - change-unlock bit clears by itself four cycles after being written.
// - reset enable reads set and stays set while watchdog reset flag is set.
// - period code 0 is 2048 ticks, doubling to code 9; codes above reserved.
// - each source sets its flag; writing zero clears; power-on clears others.
module rcw_reset_watchdog import rcw_pkg::*; #(
    parameter int unsigned WDT_BASE_TICKS = WDT_BASE_TICKS_DEF
) (
    // clock and bus reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // reset sources and watchdog oscillator (asynchronous pins)
    input wire logic por_low,
    input wire logic ext_reset_n,
    input wire logic bod_low,
    input wire logic scan_reset,
    input wire logic wdt_osc,
    // fuses and configuration
    input wire logic brownout_enable_fuse,
    input wire logic supervisor_always_on_fuse,
    input wire logic [1:0] startup_time_fuse,
    input wire logic comparator_bandgap_select,
    input wire logic adc_enable,
    // core side
    input wire logic wdt_restart,
    input wire logic wdt_irq_ack,
    // outputs
    output logic sys_reset_n,
    output logic port_init_n,
    output logic ref_enable,
    output logic wdt_irq
);

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // ========================================
    // pin sampling
    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] sync1_r, sync2_r, sync3_r, pin_q_r;

    assign pin_raw = {wdt_osc, scan_reset, bod_low, ext_reset_n, por_low};

    // level moves only when stages two and three agree
    for (genvar i = 0; i < PIN_W; i++) begin : g_pin
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                sync1_r[i] <= PIN_IDLE[i];
                sync2_r[i] <= PIN_IDLE[i];
                sync3_r[i] <= PIN_IDLE[i];
                pin_q_r[i] <= PIN_IDLE[i];
            end else begin
                sync1_r[i] <= pin_raw[i];
                sync2_r[i] <= sync1_r[i];
                sync3_r[i] <= sync2_r[i];
                if (sync2_r[i] == sync3_r[i]) begin
                    pin_q_r[i] <= sync3_r[i];
                end
            end
        end
    end

    // ========================================
    // reset combining and delay counter
    logic src_raw_n, src_act, bod_hit, wdt_rst_pulse_r, sys_reset_n_r, port_init_n_r;
    rcw_rst_state_type state_r, state_nxt;
    logic [DLY_W-1:0] dly_cnt_r, dly_sel;

    // raw pins bypass the clock so outputs drop even with no clock
    assign src_raw_n = !(por_low || !ext_reset_n || (bod_low && brownout_enable_fuse) || scan_reset);
    assign bod_hit = pin_q_r[PIN_BOD] && brownout_enable_fuse;
    assign src_act = pin_q_r[PIN_POR] || !pin_q_r[PIN_EXTN] || bod_hit
        || pin_q_r[PIN_SCAN] || wdt_rst_pulse_r;

    always_comb begin
        unique case (startup_time_fuse)
            2'h0: dly_sel = STARTUP_CYC_0;
            2'h1: dly_sel = STARTUP_CYC_1;
            2'h2: dly_sel = STARTUP_CYC_2;
            2'h3: dly_sel = STARTUP_CYC_3;
        endcase
    end

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            RST_ACTIVE: begin
                if (!src_act) begin
                    state_nxt = RST_DELAY;
                end
            end
            RST_DELAY: begin
                if (src_act) begin
                    state_nxt = RST_ACTIVE;
                end else if (dly_cnt_r == '0) begin
                    state_nxt = RST_RUN;
                end
            end
            RST_RUN: begin
                if (src_act) begin
                    state_nxt = RST_ACTIVE;
                end
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= RST_ACTIVE;
            dly_cnt_r <= '0;
        end else begin
            state_r <= state_nxt;
            if (state_r != RST_DELAY) begin
                dly_cnt_r <= dly_sel;
            end else if (dly_cnt_r != '0) begin
                dly_cnt_r <= dly_cnt_r - 16'h0001;
            end
        end
    end

    always_ff @(posedge aclk or negedge src_raw_n) begin
        if (!src_raw_n) begin
            sys_reset_n_r <= 1'b0;
            port_init_n_r <= 1'b0;
        end else if (!aresetn) begin
            sys_reset_n_r <= 1'b0;
            port_init_n_r <= 1'b0;
        end else begin
            sys_reset_n_r <= (state_nxt == RST_RUN);
            port_init_n_r <= !src_act;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ref_enable <= 1'b0;
        end else begin
            ref_enable <= brownout_enable_fuse || comparator_bandgap_select || adc_enable;
        end
    end

    assign sys_reset_n = sys_reset_n_r;
    assign port_init_n = port_init_n_r;

    // ========================================
    // watchdog
    logic osc_prev_r, osc_tick, rst_en_r, irq_en_r, irq_flag_r, unlock_r;
    logic re_eff, ie_eff, wdt_run, wdt_expire, reset_req, irq_set;
    logic [WDT_CNT_W-1:0] wdt_cnt_r, wdt_limit;
    logic [31:0] limit_wide;
    logic [3:0] per_code, period_r;
    logic [2:0] unlock_cnt_r;
    logic [FLG_W-1:0] flags_r;

    // osc edge taken from the filtered level only
    assign osc_tick = pin_q_r[PIN_OSC] && !osc_prev_r;
    assign re_eff = supervisor_always_on_fuse || rst_en_r || flags_r[FLG_WDT];
    assign ie_eff = irq_en_r && !supervisor_always_on_fuse;
    assign wdt_run = re_eff || ie_eff;
    // reserved codes fall back to the longest period
    assign per_code = (period_r > WDT_CODE_MAX) ? WDT_CODE_MAX : period_r;
    assign limit_wide = (32'(WDT_BASE_TICKS) << per_code) - 32'h1;
    assign wdt_limit = limit_wide[WDT_CNT_W-1:0];
    assign wdt_expire = wdt_run && osc_tick && sys_reset_n_r && (wdt_cnt_r >= wdt_limit);
    // combined mode resets when the previous interrupt was never serviced
    assign reset_req = wdt_expire && re_eff && (!ie_eff || irq_flag_r);
    assign irq_set = wdt_expire && ie_eff && !reset_req;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            osc_prev_r <= 1'b0;
            wdt_cnt_r <= '0;
            wdt_rst_pulse_r <= 1'b0;
        end else begin
            osc_prev_r <= pin_q_r[PIN_OSC];
            wdt_rst_pulse_r <= reset_req;
            if (!sys_reset_n_r || wdt_restart || !wdt_run || wdt_expire) begin
                wdt_cnt_r <= '0;
            end else if (osc_tick) begin
                wdt_cnt_r <= wdt_cnt_r + 20'h00001;
            end
        end
    end

    // ========================================
    // axi4-lite slave
    logic wr_fire, rd_fire, wr_ctrl, wr_flags, wr_ok, rd_ok, unlock_wr;
    logic [7:0] wd;
    logic [31:0] rd_mux;

    assign wr_fire = s_axi_awready && s_axi_awvalid && s_axi_wvalid;
    assign rd_fire = s_axi_arready && s_axi_arvalid;
    assign wr_ok = ({s_axi_awaddr[7:2], 2'b00} == ADDR_FLAGS)
        || ({s_axi_awaddr[7:2], 2'b00} == ADDR_CTRL);
    assign rd_ok = ({s_axi_araddr[7:2], 2'b00} == ADDR_FLAGS)
        || ({s_axi_araddr[7:2], 2'b00} == ADDR_CTRL)
        || ({s_axi_araddr[7:2], 2'b00} == ADDR_STATE);
    assign wr_flags = wr_fire && s_axi_wstrb[0] && ({s_axi_awaddr[7:2], 2'b00} == ADDR_FLAGS);
    assign wr_ctrl = wr_fire && s_axi_wstrb[0] && ({s_axi_awaddr[7:2], 2'b00} == ADDR_CTRL);
    assign wd = s_axi_wdata[7:0];
    assign unlock_wr = wd[CTL_UNLOCK] && wd[CTL_RST_EN];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_comb begin
        rd_mux = 32'h0;
        unique case ({s_axi_araddr[7:2], 2'b00})
            ADDR_FLAGS: rd_mux = {27'h0, flags_r};
            ADDR_CTRL: rd_mux = {24'h0, irq_flag_r, ie_eff, period_r[3], unlock_r,
                re_eff, period_r[2:0]};
            ADDR_STATE: rd_mux = {10'h0, sys_reset_n_r, port_init_n_r, wdt_cnt_r};
            default: rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
            if (rd_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ========================================
    // reset flags: survive internal reset, set beats a write of zero
    logic [FLG_W-1:0] flag_set, flag_clr;

    assign flag_set = {pin_q_r[PIN_SCAN], wdt_rst_pulse_r, bod_hit, !pin_q_r[PIN_EXTN],
        pin_q_r[PIN_POR]};
    assign flag_clr = wr_flags ? ~s_axi_wdata[FLG_W-1:0] : '0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags_r <= '0;
        end else if (pin_q_r[PIN_POR]) begin
            flags_r <= FLAGS_POR_ONLY;
        end else begin
            flags_r <= (flags_r & ~flag_clr) | flag_set;
        end
    end

    // ========================================
    // control register with timed unlock
    always_ff @(posedge aclk) begin
        if (!aresetn || !sys_reset_n_r) begin
            rst_en_r <= 1'b0;
            irq_en_r <= 1'b0;
            period_r <= 4'h0;
            unlock_r <= 1'b0;
            unlock_cnt_r <= 3'h0;
        end else begin
            if (wdt_irq_ack && re_eff) begin
                irq_en_r <= 1'b0;
            end else if (wr_ctrl) begin
                irq_en_r <= wd[CTL_IRQ_EN];
            end
            if (wr_ctrl && unlock_wr) begin
                unlock_r <= 1'b1;
                unlock_cnt_r <= UNLOCK_CYCLES;
                rst_en_r <= 1'b1;
            end else if (wr_ctrl && unlock_cnt_r != 3'h0 && !wd[CTL_UNLOCK]) begin
                rst_en_r <= wd[CTL_RST_EN];
                period_r <= {wd[CTL_PER_HI], wd[CTL_PER_LO+2:CTL_PER_LO]};
                unlock_r <= 1'b0;
                unlock_cnt_r <= 3'h0;
            end else begin
                if (wr_ctrl) begin
                    rst_en_r <= rst_en_r || wd[CTL_RST_EN];
                end
                if (unlock_cnt_r != 3'h0) begin
                    unlock_cnt_r <= unlock_cnt_r - 3'h1;
                    unlock_r <= (unlock_cnt_r != 3'h1);
                end
            end
        end
    end

    // interrupt flag: hardware set wins over ack and write-one clear
    always_ff @(posedge aclk) begin
        if (!aresetn || !sys_reset_n_r) begin
            irq_flag_r <= 1'b0;
            wdt_irq <= 1'b0;
        end else begin
            if (irq_set) begin
                irq_flag_r <= 1'b1;
            end else if (wdt_irq_ack || (wr_ctrl && wd[CTL_IRQ_FLAG])) begin
                irq_flag_r <= 1'b0;
            end
            wdt_irq <= irq_flag_r && ie_eff;
        end
    end

    // ========================================
    // checks
    chk_src_holds: assert property (src_act |=> !sys_reset_n_r)
        else $error("internal reset released while a source is active");
    chk_wdt_pulse_len: assert property (
        wdt_rst_pulse_r && !pin_q_r[PIN_POR] |=> !wdt_rst_pulse_r && state_r == RST_ACTIVE)
        else $error("watchdog reset pulse not one cycle");
    chk_reset_mode: assert property (
        wdt_expire && re_eff && !ie_eff |=> wdt_rst_pulse_r ##1 !sys_reset_n_r)
        else $error("reset mode expiry did not reset");
    chk_irq_raise: assert property (wdt_expire && ie_eff && !irq_flag_r |=> irq_flag_r)
        else $error("interrupt mode expiry did not raise flag");
    chk_restart_clear: assert property (wdt_restart |=> wdt_cnt_r == '0)
        else $error("restart did not clear counter");
    chk_ref_enable: assert property (
        brownout_enable_fuse || comparator_bandgap_select || adc_enable |=> ref_enable)
        else $error("reference enable missing");
    chk_unlock_clear: assert property ($rose(unlock_r) |-> ##4 !unlock_r)
        else $error("unlock bit not cleared after four cycles");
    chk_always_on: assert property (supervisor_always_on_fuse && rd_fire
        && {s_axi_araddr[7:2], 2'b00} == ADDR_CTRL
        |=> s_axi_rdata[CTL_RST_EN] && !s_axi_rdata[CTL_IRQ_EN])
        else $error("always-on fuse not forcing reset mode");
    chk_flag_lock: assert property (flags_r[FLG_WDT] && rd_fire
        && {s_axi_araddr[7:2], 2'b00} == ADDR_CTRL |=> s_axi_rdata[CTL_RST_EN])
        else $error("reset enable reads clear with flag set");
    chk_por_flags: assert property (pin_q_r[PIN_POR] |=> flags_r == FLAGS_POR_ONLY)
        else $error("power-on did not clear other flags");
    chk_late_write: assert property (wr_ctrl && unlock_cnt_r == 3'h0 && sys_reset_n_r
        |=> period_r == $past(period_r))
        else $error("period changed outside unlock window");

endmodule

// ### tb/rcw_core_model.sv
`timescale 1ns/100ps

// ========================================
// core side: restart pulses and interrupt vector entry
module rcw_core_model #(
    parameter int KICK = 30
) (
    // clock
    input wire logic aclk,
    // bench control
    input wire logic kick_en,
    input wire logic ack_en,
    // device side
    input wire logic wdt_irq,
    output logic wdt_restart,
    output logic wdt_irq_ack
);
    int cnt = 0;

    // restart well inside the shortest timeout
    always @(posedge aclk) begin
        cnt <= (cnt + 1) % KICK;
        wdt_restart <= kick_en && cnt == 0;
    end

    // vector entry only while the bench allows interrupts and the request is high, never two cycles running
    always @(posedge aclk) begin
        wdt_irq_ack <= ack_en && wdt_irq && !wdt_irq_ack;
    end
endmodule

// ### tb/tb_rcw_reset_watchdog.sv
`timescale 1ns/100ps

module tb_rcw_reset_watchdog import rcw_pkg::*;;
    logic aclk = 0, aresetn = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic por_low = 0, ext_reset_n = 1, bod_low = 0, scan_reset = 0, wdt_osc = 0;
    logic brownout_enable_fuse = 0, supervisor_always_on_fuse = 0;
    logic comparator_bandgap_select = 0, adc_enable = 0;
    logic [1:0] startup_time_fuse = 0;
    logic wdt_restart, wdt_irq_ack, sys_reset_n, port_init_n, ref_enable, wdt_irq;
    logic kick_en = 0, ack_en = 0;
    int fails = 0, checked = 0, seed = 32'he289, oc = 0, n = 0, m_flags = 0;
    int fb[4] = '{FLG_EXT, FLG_BOD, FLG_SCAN, FLG_POR};

    rcw_reset_watchdog #(.WDT_BASE_TICKS(4)) i_rcw_reset_watchdog (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .por_low,
        .ext_reset_n, .bod_low, .scan_reset, .wdt_osc, .brownout_enable_fuse,
        .supervisor_always_on_fuse, .startup_time_fuse, .comparator_bandgap_select,
        .adc_enable, .wdt_restart, .wdt_irq_ack, .sys_reset_n, .port_init_n,
        .ref_enable, .wdt_irq);
    rcw_core_model #(.KICK(30)) i_rcw_core_model (.aclk, .kick_en, .ack_en,
        .wdt_irq, .wdt_restart, .wdt_irq_ack);

    always #20 aclk = ~aclk;
    // watchdog oscillator: one tick every 20 system clocks
    always @(posedge aclk) begin
        oc <= (oc + 1) % 10;
        if (oc == 9) wdt_osc <= ~wdt_osc;
    end

    // ========================================
    // shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int k;
        logic aw, w;
        k = 0;
        aw = 0;
        w = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw && w) && k < 64) begin
            @(posedge aclk);
            k++;
            if (s_axi_awready === 1'b1) begin
                aw = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wready === 1'b1) begin
                w = 1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1 && ++k < 128);
        if (k >= 128) fails++;
        // bready stays up so back-to-back calls never drive it twice in one step
        resp = s_axi_bresp;
    endtask

    task automatic rdr(input logic [7:0] a);
        int k;
        k = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            k++;
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && k < 64);
        if (s_axi_rvalid !== 1'b1) fails++;
        rd = s_axi_rdata;
        resp = s_axi_rresp;
    endtask

    task automatic wait_rst(input logic lvl);
        n = 0;
        while (sys_reset_n !== lvl && n < 600) begin
            @(posedge aclk);
            n++;
        end
        chk(sys_reset_n, lvl);
    endtask

    task automatic set_src(input int s, input logic v);
        case (s)
            0: ext_reset_n <= !v;
            1: bod_low <= v;
            2: scan_reset <= v;
            default: por_low <= v;
        endcase
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    initial begin
        #(40 * 20000);
        fails++;
        summarize();
    end

    // ========================================
    // tests
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        brownout_enable_fuse <= 1'b1;
        wait_rst(1'b1);
        rdr(ADDR_CTRL);
        chk(rd, 32'h0);
        wr(ADDR_FLAGS, 32'h0);
        chk(resp, RESP_OKAY);
        for (int s = 0; s < 4; s++) begin
            @(posedge aclk);
            startup_time_fuse <= s[1:0];
            set_src(s, 1'b1);
            #1 chk(port_init_n, 1'b0);
            repeat (6) @(posedge aclk);
            chk(sys_reset_n, 1'b0);
            set_src(s, 1'b0);
            repeat (4 << (2 * s)) @(posedge aclk);
            chk(sys_reset_n, 1'b0);
            wait_rst(1'b1);
            m_flags = (s == 3) ? 1 << FLG_POR : m_flags | (1 << fb[s]);
            rdr(ADDR_FLAGS);
            chk(rd, m_flags);
        end
        $display("test reset sources done");
        repeat (8) begin
            @(posedge aclk);
            {brownout_enable_fuse, comparator_bandgap_select, adc_enable} <= 3'($random(seed));
            repeat (3) @(posedge aclk);
            chk(ref_enable, brownout_enable_fuse | comparator_bandgap_select | adc_enable);
        end
        rdr(8'h10);
        chk({rd[29:0], resp}, {30'h0, RESP_SLVERR});
        wr(ADDR_STATE, 32'h0);
        chk(resp, RESP_SLVERR);
        $display("test reference and bus done");
        kick_en <= 1'b1;
        wr(ADDR_CTRL, 32'h18);
        repeat (6) @(posedge aclk);
        rdr(ADDR_CTRL);
        chk(rd, 32'h08);
        wr(ADDR_CTRL, 32'h0);
        rdr(ADDR_CTRL);
        chk(rd, 32'h08);
        repeat (300) @(posedge aclk);
        chk(sys_reset_n, 1'b1);
        wr(ADDR_CTRL, 32'h18);
        wr(ADDR_CTRL, 32'h01);
        rdr(ADDR_CTRL);
        chk(rd, 32'h01);
        kick_en <= 1'b0;
        wr(ADDR_CTRL, 32'h40);
        n = 0;
        while (wdt_irq !== 1'b1 && n < 400) begin
            @(posedge aclk);
            n++;
        end
        // code 1 doubles the 4-tick base; each tick is 20 clocks
        chk(n >= (4 << 1) * 20 - 30 && n <= (4 << 1) * 20 + 30, 1'b1);
        chk(sys_reset_n, 1'b1);
        rdr(ADDR_CTRL);
        chk(rd, 32'hc1);
        ack_en <= 1'b1;
        repeat (4) @(posedge aclk);
        chk(wdt_irq, 1'b0);
        ack_en <= 1'b0;
        wr(ADDR_CTRL, 32'h80);
        $display("test unlock and interrupt done");
        wr(ADDR_CTRL, 32'h08);
        wait_rst(1'b0);
        kick_en <= 1'b1;
        wait_rst(1'b1);
        m_flags = m_flags | (1 << FLG_WDT);
        rdr(ADDR_FLAGS);
        chk(rd, m_flags);
        wr(ADDR_CTRL, 32'h18);
        wr(ADDR_CTRL, 32'h0);
        rdr(ADDR_CTRL);
        chk(rd, 32'h08);
        m_flags = m_flags & ~(1 << FLG_WDT);
        wr(ADDR_FLAGS, m_flags);
        wr(ADDR_CTRL, 32'h18);
        wr(ADDR_CTRL, 32'h0);
        rdr(ADDR_CTRL);
        chk(rd, 32'h0);
        $display("test watchdog reset done");
        kick_en <= 1'b0;
        wr(ADDR_CTRL, 32'h48);
        n = 0;
        while (wdt_irq !== 1'b1 && n < 400) begin
            @(posedge aclk);
            n++;
        end
        chk({sys_reset_n, wdt_irq}, 2'b11);
        ack_en <= 1'b1;
        repeat (4) @(posedge aclk);
        rdr(ADDR_CTRL);
        chk(rd, 32'h08);
        ack_en <= 1'b0;
        wait_rst(1'b0);
        kick_en <= 1'b1;
        wait_rst(1'b1);
        $display("test combined mode done");
        supervisor_always_on_fuse <= 1'b1;
        wr(ADDR_CTRL, 32'h40);
        rdr(ADDR_CTRL);
        chk(rd & 32'h48, 32'h08);
        kick_en <= 1'b0;
        wait_rst(1'b0);
        kick_en <= 1'b1;
        wait_rst(1'b1);
        $display("test always-on done");
        summarize();
    end
endmodule
